// ---- logic/tap_port3.sv ----
`timescale 1ns/1ps
`include "tap_regs.svh"
module tap_port3 (
  // core clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_b_in,
  // register port
  input  wire tap_pkg::tap_bus_req_t bus_in,
  output logic [7:0]              rd_data_out,
  // sources in the core domain
  input  wire tap_pkg::tap_pair_t dsp12_in,
  input  wire tap_pkg::tap_pair_t dsp56_in,
  input  wire tap_pkg::tap_pair_t port1_rx_in,
  input  wire tap_pkg::tap_pair_t port2_rx_in,
  // dac path
  output tap_pkg::tap_pair_t      dac_out,
  output logic                    dac_valid_out,
  // serial link
  input  wire logic               bclk_in,
  input  wire logic               wclk_in,
  input  wire logic               din_in,
  output logic                    dout_out,
  output logic                    dout_oe_out
);
  import tap_pkg::*;

  // ---------------- core domain: registers ----------------
  logic [2:0]    fmt_reg;
  logic [1:0]    wlen_reg;
  logic          hiz_reg;
  logic [7:0]    offset_reg;
  logic [2:0]    src_reg;
  logic [1:0]    dacl_reg;
  logic [1:0]    dacr_reg;
  logic [7:0]    frame_cnt_reg;
  logic [7:0]    rd_data_reg;
  logic [7:0]    rd_data_next;
  logic [2:0]    tgl_sync_reg;
  logic          frame_evt;
  tap_link_cfg_t cfg_sh_reg;
  tap_pair_t     tx_sh;

  // ---------------- link domain ----------------
  logic [1:0]          lrst_sync_reg;
  logic                lrst_b;
  logic                wclk_prev_reg;
  logic [`TAP_CNT_W-1:0] cnt_reg;
  logic [`TAP_CNT_W-1:0] cnt_next;
  logic [`TAP_CNT_W-1:0] half_len_reg;
  logic                chan_reg;
  logic                chan_next;
  tap_link_cfg_t       cfg_l_reg;
  tap_link_cfg_t       cfg_nx;
  tap_pair_t           tx_l_reg;
  tap_pair_t           tx_nx;
  tap_pair_t           rx_acc_reg;
  tap_pair_t           rx_acc_next;
  tap_pair_t           rx_hold_reg;
  logic                frame_tgl_reg;
  logic                dout_reg;
  logic                dout_oe_reg;
  logic                pulse_mode;
  logic                anchor;
  logic                first_half;
  logic                frame_start;
  tap_slot_t           slot_tx;
  tap_slot_t           slot_rx;
  logic [`TAP_SAMPLE_W-1:0] tx_word;

  function automatic logic [`TAP_CNT_W-1:0] wlen_bits(input logic [1:0] code);
    case (code)
      2'h0:    return `TAP_WL_16;
      2'h1:    return `TAP_WL_20;
      2'h2:    return `TAP_WL_24;
      default: return `TAP_WL_32;
    endcase
  endfunction

  // maps a bit-clock position inside a half (or frame) onto a sample bit
  function automatic tap_slot_t slot_of(input tap_link_cfg_t cfg,
                                        input logic [`TAP_CNT_W-1:0] cnt,
                                        input logic [`TAP_CNT_W-1:0] hlen,
                                        input logic chan);
    logic [`TAP_CNT_W-1:0] wl;
    logic [`TAP_CNT_W-1:0] st;
    logic [`TAP_CNT_W-1:0] span;
    logic [`TAP_CNT_W-1:0] pos;
    logic [`TAP_CNT_W-1:0] k;
    tap_slot_t             s;
    wl   = wlen_bits(cfg.wlen);
    st   = {3'h0, cfg.offset};
    span = wl;
    s    = '0;
    if (cfg.fmt == TAP_FMT_I2S) begin
      st = st + `TAP_I2S_DELAY;
    end
    if (cfg.fmt == TAP_FMT_RJF && hlen > wl) begin
      st = st + (hlen - wl);
    end
    if (cfg.fmt == TAP_FMT_DSP) begin
      span = wl + wl;
    end
    pos      = cnt - st;
    s.active = (cnt >= st) && (pos < span);
    s.second = (cfg.fmt == TAP_FMT_DSP) ? (pos >= wl) : chan;
    k        = (cfg.fmt == TAP_FMT_DSP && pos >= wl) ? pos - wl : pos;
    s.bit_idx = 5'h1F - k[4:0];
    return s;
  endfunction

  // ================= core domain =================
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      fmt_reg    <= 3'h0;
      wlen_reg   <= 2'h0;
      hiz_reg    <= 1'b0;
      offset_reg <= `TAP_RST_BYTE;
      src_reg    <= 3'h0;
      dacl_reg   <= 2'h0;
      dacr_reg   <= 2'h0;
    end else if (bus_in.wr) begin
      case (bus_in.addr)
        `TAP_OFS_FMT: begin
          fmt_reg  <= bus_in.wdata[`TAP_FMT_FIELD];
          wlen_reg <= bus_in.wdata[`TAP_WLEN_FIELD];
          hiz_reg  <= bus_in.wdata[`TAP_HIZ_BIT];
        end
        `TAP_OFS_OFFSET: begin
          offset_reg <= bus_in.wdata;
        end
        `TAP_OFS_SRC: begin
          src_reg <= bus_in.wdata[`TAP_SRC_FIELD];
        end
        `TAP_OFS_DAC: begin
          dacl_reg <= bus_in.wdata[`TAP_DACL_FIELD];
          dacr_reg <= bus_in.wdata[`TAP_DACR_FIELD];
        end
        default: begin
        end
      endcase
    end
  end

  // reserved bits and unmapped offsets read as zero
  always_comb begin
    rd_data_next = `TAP_RST_BYTE;
    case (bus_in.addr)
      `TAP_OFS_FMT: begin
        rd_data_next[`TAP_FMT_FIELD]  = fmt_reg;
        rd_data_next[`TAP_WLEN_FIELD] = wlen_reg;
        rd_data_next[`TAP_HIZ_BIT]    = hiz_reg;
      end
      `TAP_OFS_OFFSET: rd_data_next = offset_reg;
      `TAP_OFS_SRC:    rd_data_next[`TAP_SRC_FIELD] = src_reg;
      `TAP_OFS_DAC: begin
        rd_data_next[`TAP_DACL_FIELD] = dacl_reg;
        rd_data_next[`TAP_DACR_FIELD] = dacr_reg;
      end
      `TAP_OFS_STAT:   rd_data_next = frame_cnt_reg;
      default:         rd_data_next = `TAP_RST_BYTE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rd_data_reg <= `TAP_RST_BYTE;
    end else begin
      rd_data_reg <= bus_in.rd ? rd_data_next : `TAP_RST_BYTE;
    end
  end

  // frame toggle crossing; stage 0 feeds stage 1 only
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tgl_sync_reg <= 3'h0;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], frame_tgl_reg};
    end
  end

  assign frame_evt = tgl_sync_reg[2] ^ tgl_sync_reg[1];

  // shadow only moves right after a frame start, so the link never sees it mid-change
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cfg_sh_reg    <= '0;
      frame_cnt_reg <= `TAP_RST_BYTE;
    end else if (frame_evt) begin
      cfg_sh_reg.fmt    <= fmt_reg;
      cfg_sh_reg.wlen   <= wlen_reg;
      cfg_sh_reg.hiz    <= hiz_reg;
      cfg_sh_reg.offset <= offset_reg;
      cfg_sh_reg.out_en <= (src_reg == TAP_SRC_DSP12) || (src_reg == TAP_SRC_DSP56) ||
                           (src_reg == TAP_SRC_LOOP1) || (src_reg == TAP_SRC_LOOP2) ||
                           (src_reg == TAP_SRC_LOOP3);
      frame_cnt_reg     <= frame_cnt_reg + 8'h01;
    end
  end

  // rx_hold_reg is stable for a whole frame once the event is seen
  tap_route u_route (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .evt_in        (frame_evt),
    .src_in        (src_reg),
    .dacl_in       (dacl_reg),
    .dacr_in       (dacr_reg),
    .dsp12_in      (dsp12_in),
    .dsp56_in      (dsp56_in),
    .port1_in      (port1_rx_in),
    .port2_in      (port2_rx_in),
    .port3_in      (rx_hold_reg),
    .tx_out        (tx_sh),
    .dac_out       (dac_out),
    .dac_valid_out (dac_valid_out)
  );

  // ================= link domain =================
  always_ff @(posedge bclk_in) begin
    lrst_sync_reg <= {lrst_sync_reg[0], rst_b_in};
  end

  assign lrst_b = lrst_sync_reg[1];

  // dsp and mono frames start on the word clock rise; others use both edges as halves
  always_comb begin
    pulse_mode  = (cfg_l_reg.fmt == TAP_FMT_DSP) || (cfg_l_reg.fmt == TAP_FMT_MONO);
    anchor      = pulse_mode ? (wclk_in & ~wclk_prev_reg) : (wclk_in ^ wclk_prev_reg);
    first_half  = pulse_mode ? 1'b1 : ((cfg_l_reg.fmt == TAP_FMT_I2S) ? ~wclk_in : wclk_in);
    frame_start = anchor & first_half;
    cnt_next    = anchor ? '0 : ((cnt_reg == `TAP_CNT_MAX) ? cnt_reg : cnt_reg + 11'h001);
    chan_next   = anchor ? ~first_half : chan_reg;
    cfg_nx      = frame_start ? cfg_sh_reg : cfg_l_reg;
    tx_nx       = frame_start ? tx_sh : tx_l_reg;
    slot_tx     = slot_of(cfg_nx, cnt_next, anchor ? cnt_reg + 11'h001 : half_len_reg, chan_next);
    slot_rx     = slot_of(cfg_l_reg, cnt_reg, half_len_reg, chan_reg);
    tx_word     = slot_tx.second ? tx_nx.right : tx_nx.left;
  end

  // mono frames carry only the first channel
  always_comb begin
    rx_acc_next = rx_acc_reg;
    if (slot_rx.active) begin
      if (slot_rx.second) begin
        rx_acc_next.right[slot_rx.bit_idx] = din_in;
      end else begin
        rx_acc_next.left[slot_rx.bit_idx] = din_in;
      end
    end
  end

  always_ff @(posedge bclk_in) begin
    if (!lrst_b) begin
      wclk_prev_reg <= 1'b0;
      cnt_reg       <= `TAP_CNT_MAX;
      half_len_reg  <= '0;
      chan_reg      <= 1'b0;
    end else begin
      wclk_prev_reg <= wclk_in;
      cnt_reg       <= cnt_next;
      chan_reg      <= chan_next;
      if (anchor) begin
        half_len_reg <= cnt_reg + 11'h001;
      end
    end
  end

  always_ff @(posedge bclk_in) begin
    if (!lrst_b) begin
      cfg_l_reg     <= '0;
      tx_l_reg      <= '0;
      rx_acc_reg    <= '0;
      rx_hold_reg   <= '0;
      frame_tgl_reg <= 1'b0;
    end else if (frame_start) begin
      cfg_l_reg     <= cfg_sh_reg;
      tx_l_reg      <= tx_sh;
      rx_hold_reg   <= rx_acc_next;
      rx_acc_reg    <= '0;
      frame_tgl_reg <= ~frame_tgl_reg;
    end else begin
      rx_acc_reg <= rx_acc_next;
    end
  end

  // a disabled source keeps the pin released regardless of the hiz bit
  always_ff @(posedge bclk_in) begin
    if (!lrst_b) begin
      dout_reg    <= 1'b0;
      dout_oe_reg <= 1'b0;
    end else begin
      dout_reg    <= cfg_nx.out_en & slot_tx.active & tx_word[slot_tx.bit_idx];
      dout_oe_reg <= cfg_nx.out_en & (~cfg_nx.hiz | slot_tx.active);
    end
  end

  assign rd_data_out = rd_data_reg;
  assign dout_out    = dout_reg;
  assign dout_oe_out = dout_oe_reg;
endmodule

// ---- inc/tap_regs.svh ----
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

// register offsets
`define TAP_OFS_FMT     8'h21
`define TAP_OFS_OFFSET  8'h22
`define TAP_OFS_RSV_23  8'h23
`define TAP_OFS_RSV_24  8'h24
`define TAP_OFS_RSV_25  8'h25
`define TAP_OFS_RSV_26  8'h26
`define TAP_OFS_SRC     8'h27
`define TAP_OFS_DAC     8'h28
`define TAP_OFS_RSV_29  8'h29
`define TAP_OFS_STAT    8'h30

// field positions
`define TAP_FMT_FIELD   7:5
`define TAP_WLEN_FIELD  4:3
`define TAP_HIZ_BIT     0
`define TAP_SRC_FIELD   2:0
`define TAP_DACL_FIELD  7:6
`define TAP_DACR_FIELD  5:4

// reset values and widths
`define TAP_RST_BYTE    8'h00
`define TAP_SAMPLE_W    32
`define TAP_CNT_W       11
`define TAP_CNT_MAX     11'h7FF

// word lengths and i2s delay in bit clocks
`define TAP_WL_16       11'h010
`define TAP_WL_20       11'h014
`define TAP_WL_24       11'h018
`define TAP_WL_32       11'h020
`define TAP_I2S_DELAY   11'h001
`endif

// ---- inc/tap_pkg.sv ----
`include "tap_regs.svh"
package tap_pkg;
  typedef enum logic [2:0] {
    TAP_FMT_I2S  = 3'h0,
    TAP_FMT_DSP  = 3'h1,
    TAP_FMT_RJF  = 3'h2,
    TAP_FMT_LJF  = 3'h3,
    TAP_FMT_MONO = 3'h4
  } tap_fmt_t;

  typedef enum logic [2:0] {
    TAP_SRC_OFF   = 3'h0,
    TAP_SRC_DSP12 = 3'h1,
    TAP_SRC_LOOP1 = 3'h2,
    TAP_SRC_LOOP2 = 3'h3,
    TAP_SRC_LOOP3 = 3'h4,
    TAP_SRC_DSP56 = 3'h6
  } tap_src_t;

  typedef enum logic [1:0] {
    TAP_DAC_OFF  = 2'h0,
    TAP_DAC_SAME = 2'h1,
    TAP_DAC_SWAP = 2'h2,
    TAP_DAC_MONO = 2'h3
  } tap_dac_t;

  typedef struct packed {
    logic [`TAP_SAMPLE_W-1:0] left;
    logic [`TAP_SAMPLE_W-1:0] right;
  } tap_pair_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tap_bus_req_t;

  typedef struct packed {
    logic [2:0] fmt;
    logic [1:0] wlen;
    logic       hiz;
    logic [7:0] offset;
    logic       out_en;
  } tap_link_cfg_t;

  typedef struct packed {
    logic       active;
    logic       second;
    logic [4:0] bit_idx;
  } tap_slot_t;
endpackage

// ---- logic/tap_route.sv ----
`timescale 1ns/1ps
`include "tap_regs.svh"
module tap_route (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  // frame event and selects
  input  wire logic              evt_in,
  input  wire logic [2:0]        src_in,
  input  wire logic [1:0]        dacl_in,
  input  wire logic [1:0]        dacr_in,
  // candidate sources
  input  wire tap_pkg::tap_pair_t dsp12_in,
  input  wire tap_pkg::tap_pair_t dsp56_in,
  input  wire tap_pkg::tap_pair_t port1_in,
  input  wire tap_pkg::tap_pair_t port2_in,
  input  wire tap_pkg::tap_pair_t port3_in,
  // routed results
  output tap_pkg::tap_pair_t     tx_out,
  output tap_pkg::tap_pair_t     dac_out,
  output logic                   dac_valid_out
);
  import tap_pkg::*;

  tap_pair_t tx_reg;
  tap_pair_t dac_reg;
  logic      dac_valid_reg;

  // halving keeps full-scale inputs from wrapping
  function automatic logic [`TAP_SAMPLE_W-1:0] mono_mix(input logic [`TAP_SAMPLE_W-1:0] a,
                                                       input logic [`TAP_SAMPLE_W-1:0] b);
    logic signed [`TAP_SAMPLE_W:0] sum;
    sum = $signed({a[`TAP_SAMPLE_W-1], a}) + $signed({b[`TAP_SAMPLE_W-1], b});
    return sum[`TAP_SAMPLE_W:1];
  endfunction

  function automatic logic [`TAP_SAMPLE_W-1:0] dac_pick(input logic [1:0] sel,
                                                       input logic [`TAP_SAMPLE_W-1:0] same,
                                                       input logic [`TAP_SAMPLE_W-1:0] other);
    case (sel)
      TAP_DAC_OFF:  return '0;
      TAP_DAC_SAME: return same;
      TAP_DAC_SWAP: return other;
      default:      return mono_mix(same, other);
    endcase
  endfunction

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tx_reg <= '0;
    end else if (evt_in) begin
      case (src_in)
        TAP_SRC_DSP12: tx_reg <= dsp12_in;
        TAP_SRC_DSP56: tx_reg <= dsp56_in;
        TAP_SRC_LOOP1: tx_reg <= port1_in;
        TAP_SRC_LOOP2: tx_reg <= port2_in;
        TAP_SRC_LOOP3: tx_reg <= port3_in;
        default:       tx_reg <= '0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      dac_reg <= '0;
    end else if (evt_in) begin
      dac_reg.left  <= dac_pick(dacl_in, port3_in.left, port3_in.right);
      dac_reg.right <= dac_pick(dacr_in, port3_in.right, port3_in.left);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      dac_valid_reg <= 1'b0;
    end else begin
      dac_valid_reg <= evt_in;
    end
  end

  assign tx_out        = tx_reg;
  assign dac_out       = dac_reg;
  assign dac_valid_out = dac_valid_reg;
endmodule

// ---- sim/tap_port3_asserts.sv ----
`timescale 1ns/1ps
module tap_port3_asserts (
  // clocks and reset
  input wire logic                 clk_in,
  input wire logic                 rst_b_in,
  input wire logic                 bclk_in,
  // register port
  input wire tap_pkg::tap_bus_req_t bus_in,
  input wire logic [7:0]           rd_data_out,
  // dac path and pin
  input wire tap_pkg::tap_pair_t   dac_out,
  input wire logic                 dac_valid_out,
  input wire logic                 dout_out,
  input wire logic                 dout_oe_out
);
  import tap_pkg::*;
  logic [7:0] fmt_reg;
  logic [7:0] off_reg;
  logic [7:0] src_reg;
  logic [7:0] dac_reg;
  logic [9:0] quiet_reg;
  logic       settled;
  // a write lands two frames later, so outputs are judged only after a quiet spell
  assign settled = quiet_reg == 10'h258;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || bus_in.wr) quiet_reg <= 10'h000;
    else if (!settled) quiet_reg <= quiet_reg + 10'h001;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      fmt_reg <= 8'h00;
      off_reg <= 8'h00;
      src_reg <= 8'h00;
      dac_reg <= 8'h00;
    end else if (bus_in.wr) begin
      if (bus_in.addr == 8'h21) fmt_reg <= bus_in.wdata;
      if (bus_in.addr == 8'h22) off_reg <= bus_in.wdata;
      if (bus_in.addr == 8'h27) src_reg <= bus_in.wdata;
      if (bus_in.addr == 8'h28) dac_reg <= bus_in.wdata;
    end
  end
  sequence rd_at_s(logic [7:0] a);
    bus_in.rd && bus_in.addr == a;
  endsequence
  sequence dac_evt_s;
    settled && dac_valid_out;
  endsequence
  rd_offset_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rd_at_s(8'h22) |=> rd_data_out == off_reg) else $error("offset readback wrong");
  rd_format_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rd_at_s(8'h21) |=> rd_data_out == fmt_reg) else $error("format readback wrong");
  rd_reserved_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    bus_in.rd && bus_in.addr inside {8'h23, 8'h24, 8'h25, 8'h26, 8'h29} |=> rd_data_out == 8'h00)
    else $error("reserved read not zero");
  src_off_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    settled && src_reg[2:0] == 3'h0 |-> !dout_oe_out) else $error("pin driven while source off");
  drive_on_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    settled && !fmt_reg[0] && src_reg[2:0] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6} |-> dout_oe_out)
    else $error("pin released with hiz clear");
  dac_off_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    dac_evt_s |-> (dac_reg[7:6] != 2'h0 || dac_out.left == '0) && (dac_reg[5:4] != 2'h0 || dac_out.right == '0))
    else $error("dac off not zero");
  dac_pair_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    dac_evt_s ##0 (dac_reg[7:4] inside {4'hF, 4'h6, 4'h9}) |-> dac_out.left == dac_out.right)
    else $error("dac sides differ");
  dac_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    dac_valid_out |=> (!dac_valid_out) [*8]) else $error("dac update too often");
  quiet_line_a: assert property (@(posedge bclk_in) disable iff (!rst_b_in)
    !dout_oe_out |-> !dout_out) else $error("data on released pin");
endmodule
bind tap_port3 tap_port3_asserts tap_port3_asserts_inst (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .bclk_in(bclk_in), .bus_in(bus_in), .rd_data_out(rd_data_out),
  .dac_out(dac_out), .dac_valid_out(dac_valid_out), .dout_out(dout_out), .dout_oe_out(dout_oe_out));

// ---- sim/tap_host.sv ----
`timescale 1ns/1ps
module tap_host (
  // link
  output logic        bclk_out,
  output logic        wclk_out,
  output logic        din_out,
  input  wire logic   dout_in,
  input  wire logic   dout_oe_in,
  // bench side
  input  wire logic [63:0] tx_word_in,
  output logic [63:0] rx_word_out,
  output logic [63:0] rx_oe_out,
  output logic        frame_out
);
  logic [5:0]  cnt_reg;
  logic [63:0] rx_reg;
  logic [63:0] oe_reg;
  logic        last_reg;
  logic        line_w;
  // no pull on the pin: a released line shows the inverse of its last level
  assign line_w = dout_oe_in ? dout_in : ~last_reg;
  initial begin
    bclk_out = 1'b0;
    cnt_reg = 6'h00;
    wclk_out = 1'b0;
    din_out = 1'b0;
    last_reg = 1'b0;
    frame_out = 1'b0;
  end
  always #6 bclk_out = ~bclk_out;
  // continuous 64-bit frames; word clock high for the first 32, so pulse formats
  // see one rise per frame and half formats see a left and a right half
  always @(posedge bclk_out) begin
    cnt_reg <= cnt_reg + 6'h01;
    wclk_out <= cnt_reg == 6'h3F || cnt_reg < 6'h1F;
    din_out <= tx_word_in[6'h3F - cnt_reg];
    last_reg <= line_w;
    rx_reg <= {rx_reg[62:0], line_w};
    oe_reg <= {oe_reg[62:0], dout_oe_in};
    frame_out <= cnt_reg == 6'h00;
    if (cnt_reg == 6'h00) begin
      rx_word_out <= {rx_reg[62:0], line_w};
      rx_oe_out <= {oe_reg[62:0], dout_oe_in};
    end
  end
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import tap_pkg::*;
  logic         clk_in = 1'b0;
  logic         rst_b_in = 1'b0;
  tap_bus_req_t bus_in = '0;
  tap_pair_t    dsp12, dsp56, p1, p2, dac, src_pair;
  logic [7:0]   rd_data, dac_code;
  logic         dac_valid, bclk, wclk, din, dout, oe, frame, rd_pend = 1'b0;
  logic [63:0]  tx_word = '0, rx_word, rx_oe;
  logic [127:0] ew;
  tap_pair_t    ed;
  logic [7:0]   rd_q[$];
  tap_pair_t    dac_q[$];
  logic [127:0] wire_q[$];
  logic [7:0]   srcs[6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h00};
  logic [7:0]   dacs[6] = '{8'hF0, 8'h60, 8'h90, 8'h00, 8'hB0, 8'hD0};
  integer       fail_count = 0, compares = 0, seed = 18524, off;
  tap_port3 tap_port3_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus_in), .rd_data_out(rd_data),
    .dsp12_in(dsp12), .dsp56_in(dsp56), .port1_rx_in(p1), .port2_rx_in(p2), .dac_out(dac),
    .dac_valid_out(dac_valid), .bclk_in(bclk), .wclk_in(wclk), .din_in(din), .dout_out(dout), .dout_oe_out(oe));
  tap_host tap_host_inst (.bclk_out(bclk), .wclk_out(wclk), .din_out(din), .dout_in(dout), .dout_oe_in(oe),
    .tx_word_in(tx_word), .rx_word_out(rx_word), .rx_oe_out(rx_oe), .frame_out(frame));
  always #2.5 clk_in = ~clk_in;
  task automatic report_and_stop();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_in <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w) rd_q.push_back(d);
    @(posedge clk_in);
    bus_in <= '0;
  endtask
  // waits on dac updates, which come once per received frame
  task automatic frames(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 4000) begin
      @(posedge clk_in);
      k++;
      if (dac_valid === 1'b1) n--;
    end
    if (n > 0) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  function automatic logic [127:0] wire_exp(input int w, h, o, input logic hiz, mono, en, input tap_pair_t s);
    logic [63:0] d, m;
    int k;
    d = '0;
    m = '0;
    for (int n = 0; n < 64; n++) begin
      k = n - o;
      if (en && k >= 0 && k < w) {m[63-n], d[63-n]} = {1'b1, s.left[31-k]};
      else if (en && !mono && k >= h && k < h + w) {m[63-n], d[63-n]} = {1'b1, s.right[31-k+h]};
      else m[63-n] = en && !hiz;
    end
    return {m, d};
  endfunction
  function automatic logic [31:0] pick(input logic [1:0] c, input logic [31:0] same, other);
    logic [32:0] sum;
    sum = {same[31], same} + {other[31], other};
    case (c)
      2'h1: return same;
      2'h2: return other;
      2'h3: return sum[32:1];
      default: return 32'h0000_0000;
    endcase
  endfunction
  always @(posedge clk_in) begin
    rd_pend <= bus_in.rd;
    if (rd_pend && rd_q.size() > 0) check("rd_data", 64'(rd_data), 64'(rd_q.pop_front()));
    if (dac_valid === 1'b1 && dac_q.size() > 0) begin
      ed = dac_q.pop_front();
      check("dac_left", 64'(dac.left), 64'(ed.left));
      check("dac_right", 64'(dac.right), 64'(ed.right));
    end
  end
  always @(negedge bclk) begin
    if (frame && wire_q.size() > 0) begin
      ew = wire_q.pop_front();
      check("dout_oe", rx_oe, ew[127:64]);
      check("dout", rx_word & ew[127:64], ew[63:0]);
    end
  end
  initial begin
    {dsp12, dsp56, p1, p2} = '0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int a = 8'h21; a < 8'h2A; a++) bus(1'b0, 8'(a), 8'h00);
    bus(1'b1, 8'h40, 8'hA5);
    bus(1'b0, 8'h40, 8'h00);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 8'h21, {3'(i), 2'(i), 3'h1});
      bus(1'b0, 8'h21, {3'(i), 2'(i), 3'h1});
    end
    // source 101 and 111 are never written
    for (int i = 0; i < 6; i++) begin
      dsp12 <= {$random(seed), $random(seed)};
      dsp56 <= {$random(seed), $random(seed)};
      p1 <= {$random(seed), $random(seed)};
      p2 <= {$random(seed), $random(seed)};
      tx_word <= {$random(seed), $random(seed)};
      dac_code = dacs[i];
      bus(1'b1, 8'h21, 8'h39);
      bus(1'b1, 8'h22, 8'h00);
      bus(1'b1, 8'h28, dac_code);
      bus(1'b1, 8'h27, srcs[i]);
      bus(1'b0, 8'h28, dac_code);
      frames(6);
      case (srcs[i])
        8'h01: src_pair = dsp12;
        8'h02: src_pair = p1;
        8'h03: src_pair = p2;
        8'h04: src_pair = tx_word;
        8'h06: src_pair = dsp56;
        default: src_pair = '0;
      endcase
      wire_q.push_back(wire_exp(32, 32, 0, 1'b1, 1'b0, srcs[i] != 8'h00, src_pair));
      dac_q.push_back({pick(dac_code[7:6], tx_word[63:32], tx_word[31:0]),
                       pick(dac_code[5:4], tx_word[31:0], tx_word[63:32])});
      frames(2);
    end
    // the main loop leaves the source disabled; offset passes need a live source
    bus(1'b1, 8'h27, 8'h06);
    // last pass is left-justified halves, so the offset must leave room in each half
    for (int j = 0; j < 4; j++) begin
      off = $unsigned($random(seed)) % ((j == 3) ? 17 : 33);
      bus(1'b1, 8'h21, {(j == 2) ? 3'h4 : ((j == 3) ? 3'h3 : 3'h1), 2'h0, 2'h0, j != 1});
      bus(1'b1, 8'h22, 8'(off));
      bus(1'b0, 8'h22, 8'(off));
      frames(6);
      wire_q.push_back(wire_exp(16, (j == 3) ? 32 : 16, off, j != 1, j == 2, 1'b1, dsp56));
      frames(2);
    end
    check("pending", 64'(wire_q.size() + dac_q.size() + rd_q.size()), 64'h0000_0000_0000_0000);
    report_and_stop();
  end
endmodule
